// ### core/synth2_cfg_consts.svh
/*
  Offsets, reset values, field positions and widths for the second
  synthesizer spread and output configuration bank.
  Assumes byte addressing on the register port and byte-wide registers.
*/
`ifndef SYNTH2_CFG_CONSTS_SVH
`define SYNTH2_CFG_CONSTS_SVH

// register byte offsets
`define OFS_SYNTH2_SPREAD_STEP_LOW     8'h14
`define OFS_SYNTH2_SPREAD_DELTA        8'h15
`define OFS_SYNTH2_SPREAD_STEP_HIGH    8'h16
`define OFS_SYNTH2_SPREAD_PERIOD_LOW   8'h17
`define OFS_SYNTH2_LOOP_CONTROL        8'h18
`define OFS_SYNTH2_CHARGE_PUMP         8'h19
`define OFS_SYNTH2_REFERENCE_DIVIDER   8'h1A
`define OFS_OUTPUT_DIVIDER_THREE_FOUR  8'h1B
`define OFS_SYNTH_OPERATION_CONTROL    8'h1C
`define OFS_OUTPUT_CONTROL             8'h1D
`define BANK_FIRST_OFS                 8'h14
`define BANK_LAST_OFS                  8'h1D
`define BANK_NUM_REGS                  10
`define BANK_IDX_W                     4

// power-up values, listed from the first offset to the last
`define RST_SYNTH2_SPREAD_STEP_LOW     8'h00
`define RST_SYNTH2_SPREAD_DELTA        8'h00
`define RST_SYNTH2_SPREAD_STEP_HIGH    8'h00
`define RST_SYNTH2_SPREAD_PERIOD_LOW   8'h00
`define RST_SYNTH2_LOOP_CONTROL        8'h0E
`define RST_SYNTH2_CHARGE_PUMP         8'h14
`define RST_SYNTH2_REFERENCE_DIVIDER   8'h19
`define RST_OUTPUT_DIVIDER_THREE_FOUR  8'h43
`define RST_SYNTH_OPERATION_CONTROL    8'h3F
`define RST_OUTPUT_CONTROL             8'h33
`define RST_READ_DATA                  8'h00
`define UNMAPPED_READ_VALUE            8'h00

// loop control fields
`define POS_PERIOD_HIGH_MSB            7
`define POS_PERIOD_HIGH_LSB            6
`define POS_SPREAD_ENABLE              5
`define POS_FILTER_RES_100K            4
`define POS_FILTER_RES_50K             3
`define POS_FILTER_RES_25K             2
`define POS_FILTER_RES_12K5            1
`define POS_FILTER_RES_6K_ONLY         0

// charge pump fields
`define POS_PUMP_X16                   7
`define POS_PUMP_X8                    6
`define POS_PUMP_X4                    5
`define POS_PUMP_X2                    4
`define POS_PUMP_X1                    3
`define POS_PUMP_DIV24                 2
`define POS_PUMP_DIV3                  1
`define POS_REF_CURRENT_SEL            0

// reference divider fields
`define POS_REF_DOUBLER_EN             7
`define POS_REF_BYPASS_DIV1            6
`define POS_REF_BYPASS_SECOND_DIVIDER_OUTPUT            5
`define POS_REF_DIVIDE_MSB             4
`define POS_REF_DIVIDE_LSB             0
`define REF_DIVIDE_W                   5
`define REF_FIXED_DIV1                 5'h01
`define REF_FIXED_SECOND_DIVIDER_OUTPUT                 5'h02

// output divider fields
`define POS_THIRD_DIV_MSB              7
`define POS_THIRD_DIV_LSB              4
`define POS_FOURTH_DIV_MSB             3
`define POS_FOURTH_DIV_LSB             0

// operation control fields
`define POS_SPREAD_HIRES_EN            7
`define POS_REF_SOURCE_SEL             6
`define POS_SYNTH3_RUN                 5
`define POS_SYNTH3_LOCK_USE            4
`define POS_SYNTH2_RUN                 3
`define POS_SYNTH2_LOCK_USE            2
`define POS_SYNTH1_RUN                 1
`define POS_SYNTH1_LOCK_USE            0
`define HIRES_SHIFT                    4

// output control fields
`define POS_DIFF1_PIN_GATE             7
`define POS_DIFF2_PIN_GATE             6
`define POS_DIFF1_ENABLE               5
`define POS_DIFF2_ENABLE               4
`define POS_FOURTH_DIV_SOURCE          3
`define POS_SINGLE1_DRIVE              2
`define POS_BANK1_LEVEL_MSB            1
`define POS_BANK1_LEVEL_LSB            0

`endif

// ### core/synth2_cfg_pkg.sv
/*
  Types shared by the second synthesizer configuration bank.
  Assumes synth2_cfg_consts.svh supplies the numeric constants.
*/
package synth2_cfg_pkg;

  typedef logic [7:0] reg_byte_t;

  typedef enum logic [1:0] {
    BANK1_LEVEL_1V8 = 2'h3
  } bank1_level_e;

  typedef enum logic {
    REF_FROM_CRYSTAL = 1'b0,
    REF_FROM_SECOND_DIVIDER_OUTPUT    = 1'b1
  } ref_source_e;

  typedef enum logic {
    FOURTH_FROM_SYNTH2  = 1'b0,
    FOURTH_FROM_CRYSTAL = 1'b1
  } fourth_source_e;

endpackage

// ### core/synth2_spread_and_output_config_bank.sv
/*
  Byte-wide configuration bank at offsets 0x14 to 0x1D: second synthesizer
  spread, loop filter, charge pump and reference divider settings, power-down
  and lock controls of three synthesizers, output divider and output controls.
  Assumes the serial protocol engine outside presents decoded byte writes and
  reads on the register port, synchronous to core_clk_i.
*/
// Function
// - eight-bit read/write spread delta at 0x15, resets to zero
// - spread step bits 15..8 at 0x16, read/write, resets to zero
// - spread step bits 7..0 at 0x14, giving a sixteen-bit step
// - ten-bit spread period from 0x17 plus 0x18 bits 7..6 as top
// - 0x18 bit 5 enables spread modulation, off after reset
// - 0x18 bits 4..0 select loop-filter resistors, reset 01110
// - 0x19 bits 7..1 weight charge pump; x2 and /24 set at reset
// - 0x19 bit 0 picks 20 uA reference current, else 10 uA
// - 0x1A bits 4..0 give reference divide, reset value 25
// - 0x1A bit 7 enables reference doubler, off after reset
// - 0x1A bit 6 bypasses divider with /1, bit 5 with /2
// - 0x1B holds third divider (reset 0100) and fourth (reset 0011)
// - 0x1C bit 7 selects high-resolution spread, step shifted four bits
// - 0x1C bit 6 feeds synthesizer two from divider two, else crystal
// - 0x1C bits 5,3,1 zero power down synthesizers three, two, one
// - 0x1C bits 4,2,0 zero bypass lock of synthesizers three, two, one
// - 0x1D bits 7,6 put differential outputs under second gate pin
// - 0x1D bits 5,4 enable differential outputs one and two
// - 0x1D bit 3 clocks fourth divider from crystal, else synthesizer two
// - 0x1D bit 2 selects strong drive on single-ended output one
// - 0x1D bits 1..0 select bank one supply level, 11 is 1.8 V
`include "synth2_cfg_consts.svh"

module synth2_spread_and_output_config_bank (
  input  wire logic        core_clk_i,                 // bank clock, 125 MHz
  input  wire logic        reset_i,                    // async reset, active high
  input  wire logic        reg_wr_i,                   // byte write strobe
  input  wire logic        reg_rd_i,                   // byte read strobe
  input  wire logic [7:0]  reg_addr_i,                 // register byte offset
  input  wire logic [7:0]  reg_wdata_i,                // write data
  input  wire logic        second_output_gate_pin_i,   // second output-enable pin
  output logic      [7:0]  reg_rdata_o,                // read data, held
  output logic             reg_rvalid_o,               // read data valid pulse
  output logic             reg_hit_o,                  // last access was mapped
  output logic      [15:0] synth2_spread_step_o,       // raw sixteen-bit step
  output logic      [19:0] synth2_spread_step_eff_o,   // step after resolution shift
  output logic      [7:0]  synth2_spread_delta_o,      // step delta
  output logic      [9:0]  synth2_spread_period_o,     // spread period
  output logic             synth2_spread_enable_o,     // spread modulation on
  output logic             synth2_spread_active_o,     // spread on and synth running
  output logic             synth2_spread_hires_en_o,   // high-resolution spread
  output logic             synth2_filter_res_100k_o,   // add 100k resistor
  output logic             synth2_filter_res_50k_o,    // add 50k resistor
  output logic             synth2_filter_res_25k_o,    // add 25k resistor
  output logic             synth2_filter_res_12k5_o,   // add 12.5k resistor
  output logic             synth2_filter_res_6k_only_o, // 6k resistor only
  output logic      [6:0]  synth2_pump_weight_o,       // x16,x8,x4,x2,x1,/24,/3
  output logic             synth2_ref_current_sel_o,   // 1: 20 uA, 0: 10 uA
  output logic             synth2_ref_doubler_en_o,    // reference doubler on
  output logic             synth2_ref_bypass_div1_o,   // fixed /1 path
  output logic             synth2_ref_bypass_second_divider_output_o,   // fixed /2 path
  output logic      [4:0]  synth2_ref_divide_value_o,  // programmable divide
  output logic      [4:0]  synth2_ref_divide_eff_o,    // divide actually applied
  output logic      [3:0]  third_out_divider_o,        // third divider control
  output logic      [3:0]  fourth_out_divider_o,       // fourth divider control
  output logic             synth2_ref_source_sel_o,    // 0 crystal, 1 divider two
  output logic      [2:0]  synth_run_o,                // run bits, synth 3..1
  output logic      [2:0]  synth_lock_use_o,           // lock bits, synth 3..1
  output logic             diff_out1_pin_gate_o,       // out1 under gate pin
  output logic             diff_out2_pin_gate_o,       // out2 under gate pin
  output logic             diff_out1_enable_o,         // out1 enable bit
  output logic             diff_out2_enable_o,         // out2 enable bit
  output logic             diff_out1_active_o,         // out1 driving now
  output logic             diff_out2_active_o,         // out2 driving now
  output logic             fourth_divider_source_o,    // 0 synth two, 1 crystal
  output logic             single_out1_drive_o,        // strong drive
  output logic      [1:0]  bank1_supply_level_o        // bank one level code
);

  ////////////////////////////////////////////////////////////////////////////
  // storage and decode

  localparam synth2_cfg_pkg::reg_byte_t RST_VAL [`BANK_NUM_REGS] = '{
    `RST_SYNTH2_SPREAD_STEP_LOW,
    `RST_SYNTH2_SPREAD_DELTA,
    `RST_SYNTH2_SPREAD_STEP_HIGH,
    `RST_SYNTH2_SPREAD_PERIOD_LOW,
    `RST_SYNTH2_LOOP_CONTROL,
    `RST_SYNTH2_CHARGE_PUMP,
    `RST_SYNTH2_REFERENCE_DIVIDER,
    `RST_OUTPUT_DIVIDER_THREE_FOUR,
    `RST_SYNTH_OPERATION_CONTROL,
    `RST_OUTPUT_CONTROL
  };

  synth2_cfg_pkg::reg_byte_t regs_r [`BANK_NUM_REGS];

  wire logic                   addr_hit;
  wire logic [7:0]             addr_rel;
  wire logic [`BANK_IDX_W-1:0] addr_idx;
  wire logic [7:0]             rdata_nxt;

  assign addr_hit = (reg_addr_i >= `BANK_FIRST_OFS) && (reg_addr_i <= `BANK_LAST_OFS);
  assign addr_rel = reg_addr_i - `BANK_FIRST_OFS;
  assign addr_idx = addr_rel[`BANK_IDX_W-1:0];
  assign rdata_nxt = addr_hit ? regs_r[addr_idx] : `UNMAPPED_READ_VALUE;

  // one byte register per mapped offset; unmapped writes are dropped
  genvar gi;
  generate
    for (gi = 0; gi < `BANK_NUM_REGS; gi++)
    begin : g_reg
      wire logic wr_sel;
      assign wr_sel = reg_wr_i && addr_hit && (addr_idx == (`BANK_IDX_W)'(gi));
      always_ff @(posedge core_clk_i or posedge reset_i)
      begin
        if (reset_i)
          regs_r[gi] <= RST_VAL[gi];
        else if (wr_sel)
          regs_r[gi] <= reg_wdata_i;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read port

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      reg_rdata_o  <= `RST_READ_DATA;
      reg_rvalid_o <= 1'b0;
      reg_hit_o    <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
        reg_rdata_o <= rdata_nxt;
      if (reg_rd_i || reg_wr_i)
        reg_hit_o <= addr_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field views

  wire synth2_cfg_pkg::reg_byte_t step_lo;
  wire synth2_cfg_pkg::reg_byte_t delta;
  wire synth2_cfg_pkg::reg_byte_t step_hi;
  wire synth2_cfg_pkg::reg_byte_t period_lo;
  wire synth2_cfg_pkg::reg_byte_t loop_ctl;
  wire synth2_cfg_pkg::reg_byte_t pump_ctl;
  wire synth2_cfg_pkg::reg_byte_t refdiv_ctl;
  wire synth2_cfg_pkg::reg_byte_t outdiv_ctl;
  wire synth2_cfg_pkg::reg_byte_t oper_ctl;
  wire synth2_cfg_pkg::reg_byte_t out_ctl;

  assign step_lo    = regs_r[0];
  assign delta      = regs_r[1];
  assign step_hi    = regs_r[2];
  assign period_lo  = regs_r[3];
  assign loop_ctl   = regs_r[4];
  assign pump_ctl   = regs_r[5];
  assign refdiv_ctl = regs_r[6];
  assign outdiv_ctl = regs_r[7];
  assign oper_ctl   = regs_r[8];
  assign out_ctl    = regs_r[9];

  wire logic [15:0] step_full;
  wire logic [9:0]  period_full;
  wire logic [19:0] step_eff_nxt;
  wire logic [4:0]  ref_div_nxt;
  wire logic        hires;
  wire logic        spread_active_nxt;
  wire logic        diff1_active_nxt;
  wire logic        diff2_active_nxt;

  assign step_full   = {step_hi, step_lo};
  assign period_full = {loop_ctl[`POS_PERIOD_HIGH_MSB:`POS_PERIOD_HIGH_LSB],
                        period_lo};
  assign hires       = oper_ctl[`POS_SPREAD_HIRES_EN];
  // high resolution moves the step up by four bits
  assign step_eff_nxt = hires ? {step_full, {`HIRES_SHIFT{1'b0}}}
                              : {{`HIRES_SHIFT{1'b0}}, step_full};
  // fixed /1 path takes priority over fixed /2, then the programmed value
  assign ref_div_nxt = refdiv_ctl[`POS_REF_BYPASS_DIV1] ? `REF_FIXED_DIV1 :
                       refdiv_ctl[`POS_REF_BYPASS_SECOND_DIVIDER_OUTPUT] ? `REF_FIXED_SECOND_DIVIDER_OUTPUT :
                       refdiv_ctl[`POS_REF_DIVIDE_MSB:`POS_REF_DIVIDE_LSB];
  // spread only modulates a running synthesizer
  assign spread_active_nxt = loop_ctl[`POS_SPREAD_ENABLE]
                             && oper_ctl[`POS_SYNTH2_RUN];
  // a gated output follows the pin; an ungated one follows its enable only
  assign diff1_active_nxt = out_ctl[`POS_DIFF1_ENABLE]
                            && (!out_ctl[`POS_DIFF1_PIN_GATE]
                                || second_output_gate_pin_i);
  assign diff2_active_nxt = out_ctl[`POS_DIFF2_ENABLE]
                            && (!out_ctl[`POS_DIFF2_PIN_GATE]
                                || second_output_gate_pin_i);

  ////////////////////////////////////////////////////////////////////////////
  // plain field outputs, straight from the bank flops

  assign synth2_spread_step_o        = step_full;
  assign synth2_spread_delta_o       = delta;
  assign synth2_spread_period_o      = period_full;
  assign synth2_spread_enable_o      = loop_ctl[`POS_SPREAD_ENABLE];
  assign synth2_spread_hires_en_o    = hires;
  assign synth2_filter_res_100k_o    = loop_ctl[`POS_FILTER_RES_100K];
  assign synth2_filter_res_50k_o     = loop_ctl[`POS_FILTER_RES_50K];
  assign synth2_filter_res_25k_o     = loop_ctl[`POS_FILTER_RES_25K];
  assign synth2_filter_res_12k5_o    = loop_ctl[`POS_FILTER_RES_12K5];
  assign synth2_filter_res_6k_only_o = loop_ctl[`POS_FILTER_RES_6K_ONLY];
  assign synth2_pump_weight_o        = pump_ctl[`POS_PUMP_X16:`POS_PUMP_DIV3];
  assign synth2_ref_current_sel_o    = pump_ctl[`POS_REF_CURRENT_SEL];
  assign synth2_ref_doubler_en_o     = refdiv_ctl[`POS_REF_DOUBLER_EN];
  assign synth2_ref_bypass_div1_o    = refdiv_ctl[`POS_REF_BYPASS_DIV1];
  assign synth2_ref_bypass_second_divider_output_o    = refdiv_ctl[`POS_REF_BYPASS_SECOND_DIVIDER_OUTPUT];
  assign synth2_ref_divide_value_o   =
    refdiv_ctl[`POS_REF_DIVIDE_MSB:`POS_REF_DIVIDE_LSB];
  assign third_out_divider_o  = outdiv_ctl[`POS_THIRD_DIV_MSB:`POS_THIRD_DIV_LSB];
  assign fourth_out_divider_o = outdiv_ctl[`POS_FOURTH_DIV_MSB:`POS_FOURTH_DIV_LSB];
  assign synth2_ref_source_sel_o = oper_ctl[`POS_REF_SOURCE_SEL];
  assign synth_run_o      = {oper_ctl[`POS_SYNTH3_RUN],
                             oper_ctl[`POS_SYNTH2_RUN],
                             oper_ctl[`POS_SYNTH1_RUN]};
  assign synth_lock_use_o = {oper_ctl[`POS_SYNTH3_LOCK_USE],
                             oper_ctl[`POS_SYNTH2_LOCK_USE],
                             oper_ctl[`POS_SYNTH1_LOCK_USE]};
  assign diff_out1_pin_gate_o    = out_ctl[`POS_DIFF1_PIN_GATE];
  assign diff_out2_pin_gate_o    = out_ctl[`POS_DIFF2_PIN_GATE];
  assign diff_out1_enable_o      = out_ctl[`POS_DIFF1_ENABLE];
  assign diff_out2_enable_o      = out_ctl[`POS_DIFF2_ENABLE];
  assign fourth_divider_source_o = out_ctl[`POS_FOURTH_DIV_SOURCE];
  assign single_out1_drive_o     = out_ctl[`POS_SINGLE1_DRIVE];
  assign bank1_supply_level_o    =
    out_ctl[`POS_BANK1_LEVEL_MSB:`POS_BANK1_LEVEL_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // derived outputs, registered one cycle after the bank

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      synth2_spread_step_eff_o <= 20'h00000;
      synth2_ref_divide_eff_o  <= 5'h19;
      synth2_spread_active_o   <= 1'b0;
      diff_out1_active_o       <= 1'b0;
      diff_out2_active_o       <= 1'b0;
    end
    else
    begin
      synth2_spread_step_eff_o <= step_eff_nxt;
      synth2_ref_divide_eff_o  <= ref_div_nxt;
      synth2_spread_active_o   <= spread_active_nxt;
      diff_out1_active_o       <= diff1_active_nxt;
      diff_out2_active_o       <= diff2_active_nxt;
    end
  end

endmodule

// ### tb/bank_chk_assertions.sv
/*
  Concurrent checks on the configuration bank register port and fields.
  Assumes binding to the bank top module; one clock domain.
*/
module bank_chk (
  input wire logic        core_clk_i,                // clock
  input wire logic        reset_i,                   // reset
  input wire logic        reg_wr_i,                  // write
  input wire logic        reg_rd_i,                  // read
  input wire logic [7:0]  reg_addr_i,                // offset
  input wire logic [7:0]  reg_wdata_i,               // wdata
  input wire logic [7:0]  reg_rdata_o,               // rdata
  input wire logic        reg_rvalid_o,              // rvalid
  input wire logic        reg_hit_o,                 // hit
  input wire logic [15:0] synth2_spread_step_o,      // step
  input wire logic [19:0] synth2_spread_step_eff_o,  // shifted step
  input wire logic [7:0]  synth2_spread_delta_o,     // delta
  input wire logic [9:0]  synth2_spread_period_o,    // period
  input wire logic        synth2_spread_enable_o,    // spread on
  input wire logic        synth2_spread_active_o,    // spread live
  input wire logic        synth2_spread_hires_en_o,  // hires
  input wire logic        synth2_ref_bypass_div1_o,  // fixed /1
  input wire logic        synth2_ref_bypass_second_divider_output_o,  // fixed /2
  input wire logic [4:0]  synth2_ref_divide_value_o, // divide
  input wire logic [4:0]  synth2_ref_divide_eff_o,   // applied divide
  input wire logic [2:0]  synth_run_o                // run bits
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_wr(logic [7:0] a);
    reg_wr_i && reg_addr_i == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  sequence s_start;
    s_wr(8'h18) ##0 (reg_wdata_i[5] && synth_run_o[1]);
  endsequence

  delta_write_a: assert property (
    s_wr(8'h15) |=> synth2_spread_delta_o == $past(reg_wdata_i))
    else $error("spread delta not written");
  step_high_a: assert property (
    s_wr(8'h16) |=> synth2_spread_step_o[15:8] == $past(reg_wdata_i))
    else $error("step high byte not written");
  step_low_a: assert property (
    s_wr(8'h14) |=> synth2_spread_step_o[7:0] == $past(reg_wdata_i))
    else $error("step low byte not written");
  period_low_a: assert property (
    s_wr(8'h17) |=> synth2_spread_period_o[7:0] == $past(reg_wdata_i))
    else $error("period low byte not written");
  period_high_a: assert property (
    s_wr(8'h18) |=> {synth2_spread_period_o[9:8], synth2_spread_enable_o}
                    == $past(reg_wdata_i[7:5]))
    else $error("period top bits or spread enable wrong");
  spread_start_a: assert property (
    s_start |=> synth2_spread_enable_o ##1 synth2_spread_active_o)
    else $error("spread did not start");
  spread_stop_a: assert property (
    !synth_run_o[1] |=> !synth2_spread_active_o)
    else $error("spread live while synth two down");
  divide_eff_a: assert property (
    synth2_ref_divide_eff_o == $past(synth2_ref_bypass_div1_o ? 5'h01 :
      synth2_ref_bypass_second_divider_output_o ? 5'h02 : synth2_ref_divide_value_o))
    else $error("applied reference divide wrong");
  hires_shift_a: assert property (
    synth2_spread_step_eff_o == $past(synth2_spread_hires_en_o ?
      {synth2_spread_step_o, 4'h0} : {4'h0, synth2_spread_step_o}))
    else $error("resolution shift wrong");
  read_back_a: assert property (
    s_rd(8'h15) |=> reg_rvalid_o && reg_hit_o
                    && reg_rdata_o == $past(synth2_spread_delta_o))
    else $error("read of delta wrong");
  unmapped_read_a: assert property (
    reg_rd_i && (reg_addr_i < 8'h14 || reg_addr_i > 8'h1D)
      |=> reg_rvalid_o && !reg_hit_o && reg_rdata_o == 8'h00)
    else $error("unmapped read not refused");
endmodule

bind synth2_spread_and_output_config_bank bank_chk i_bank_chk (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .reg_hit_o(reg_hit_o),
  .synth2_spread_step_o(synth2_spread_step_o),
  .synth2_spread_step_eff_o(synth2_spread_step_eff_o),
  .synth2_spread_delta_o(synth2_spread_delta_o),
  .synth2_spread_period_o(synth2_spread_period_o),
  .synth2_spread_enable_o(synth2_spread_enable_o),
  .synth2_spread_active_o(synth2_spread_active_o),
  .synth2_spread_hires_en_o(synth2_spread_hires_en_o),
  .synth2_ref_bypass_div1_o(synth2_ref_bypass_div1_o),
  .synth2_ref_bypass_second_divider_output_o(synth2_ref_bypass_second_divider_output_o),
  .synth2_ref_divide_value_o(synth2_ref_divide_value_o),
  .synth2_ref_divide_eff_o(synth2_ref_divide_eff_o),
  .synth_run_o(synth_run_o)
);

// ### tb/host_bfm.sv
/*
  Host model driving the bank's byte strobe port.
  Assumes every task is entered 1 ns after a rising clock edge.
*/
module host_bfm (
  input  wire logic       clk_i,    // bank clock
  input  wire logic       rvalid_i, // read valid
  input  wire logic [7:0] rdata_i,  // read data
  output logic            wr_o,     // write strobe
  output logic            rd_o,     // read strobe
  output logic      [7:0] addr_o,   // offset
  output logic      [7:0] wdata_o   // write data
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    addr_o  = 8'h00;
    wdata_o = 8'h00;
  end

  // strobe left high so writes can run back to back
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    wr_o    = 1'b1;
    rd_o    = 1'b0;
    addr_o  = a;
    wdata_o = d;
    @(posedge clk_i);
    #1;
  endtask

  task automatic idle();
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    addr_o  = ~addr_o;
    wdata_o = ~wdata_o;
    @(posedge clk_i);
    #1;
  endtask

  task automatic rd_byte(input logic [7:0] a, output logic [7:0] d, output logic ok);
    int n;
    wr_o    = 1'b0;
    rd_o    = 1'b1;
    addr_o  = a;
    wdata_o = ~wdata_o;
    @(posedge clk_i);
    #1;
    rd_o   = 1'b0;
    addr_o = ~a;
    n      = 0;
    while (!rvalid_i && n < 4)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    ok = (rvalid_i === 1'b1);
    d  = rdata_i;
    @(posedge clk_i);
    #1;
  endtask

  // fields first, enable last; spread already on at entry still sees a half update
  task automatic spread_setup(input logic [15:0] st, input logic [7:0] dl,
                              input logic [9:0] pd, input logic [4:0] flt);
    wr_byte(8'h14, st[7:0]);
    wr_byte(8'h16, st[15:8]);
    wr_byte(8'h15, dl);
    wr_byte(8'h17, pd[7:0]);
    wr_byte(8'h18, {pd[9:8], 1'b1, flt});
  endtask
endmodule

// ### tb/testbench.sv
/*
  Self-checking bench for the configuration bank.
  Assumes the host model drives the register port and the checker is bound.
*/
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        pin = 1'b0;
  logic        wr, rd, rvalid, hit, en, active, dbl, icur, hi, a1, a2, src;
  logic [5:0]  oc;
  logic [1:0]  level;
  logic [2:0]  run, lock;
  logic [3:0]  third, fourth;
  logic [4:0]  div_eff, flt;
  logic [6:0]  pump, rdiv;
  logic [7:0]  addr, wdata, rdata, delta;
  logic [9:0]  period;
  logic [15:0] step;
  logic [19:0] step_eff;
  logic [7:0]  w [10];
  logic [7:0]  dv [4] = '{8'h03, 8'hC7, 8'h27, 8'h79};
  logic [4:0]  de [4] = '{5'h03, 5'h01, 5'h02, 5'h01};
  logic [7:0]  rv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0E, 8'h14, 8'h19, 8'h43, 8'h3F, 8'h33};
  int          fail_count = 0;
  int          n_tests = 0;

  always #4 clk = ~clk;

  host_bfm i_host_bfm (.clk_i(clk), .rvalid_i(rvalid), .rdata_i(rdata), .wr_o(wr),
    .rd_o(rd), .addr_o(addr), .wdata_o(wdata));

  synth2_spread_and_output_config_bank i_synth2_spread_and_output_config_bank (
    .core_clk_i(clk), .reset_i(rst), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .second_output_gate_pin_i(pin), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .reg_hit_o(hit), .synth2_spread_step_o(step),
    .synth2_spread_step_eff_o(step_eff), .synth2_spread_delta_o(delta),
    .synth2_spread_period_o(period), .synth2_spread_enable_o(en),
    .synth2_spread_active_o(active), .synth2_spread_hires_en_o(hi),
    .synth2_filter_res_100k_o(flt[4]), .synth2_filter_res_50k_o(flt[3]),
    .synth2_filter_res_25k_o(flt[2]), .synth2_filter_res_12k5_o(flt[1]),
    .synth2_filter_res_6k_only_o(flt[0]), .synth2_pump_weight_o(pump),
    .synth2_ref_current_sel_o(icur), .synth2_ref_doubler_en_o(dbl),
    .synth2_ref_bypass_div1_o(rdiv[6]), .synth2_ref_bypass_second_divider_output_o(rdiv[5]),
    .synth2_ref_divide_value_o(rdiv[4:0]),
    .synth2_ref_divide_eff_o(div_eff), .third_out_divider_o(third),
    .fourth_out_divider_o(fourth), .synth2_ref_source_sel_o(src), .synth_run_o(run),
    .synth_lock_use_o(lock), .diff_out1_pin_gate_o(oc[5]), .diff_out2_pin_gate_o(oc[4]),
    .diff_out1_enable_o(oc[3]), .diff_out2_enable_o(oc[2]), .diff_out1_active_o(a1),
    .diff_out2_active_o(a2), .fourth_divider_source_o(oc[1]), .single_out1_drive_o(oc[0]),
    .bank1_supply_level_o(level));

  task automatic complete_run();
    if (fail_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    i_host_bfm.rd_byte(a, d, ok);
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("[ERR] %0t read answer missing", $time);
      complete_run();
    end
    else
      chk(d, exp);
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 10; i++)
      rchk(8'h14 + 8'(i), rv[i]);
    chk({third, fourth, level, run, lock}, {4'h4, 4'h3, 2'h3, 3'h7, 3'h7});
    chk({pump, icur, div_eff, a1, a2}, {7'h0A, 1'b0, 5'h19, 2'h3});
    chk({en, active, dbl, hi, step_eff}, 24'h000000);
    for (int k = 0; k < 2; k++)
    begin
      for (int i = 0; i < 10; i++)
      begin
        w[i] = (8'h5A ^ 8'(i * 8'h13)) ^ {8{k[0]}};
        i_host_bfm.wr_byte(8'h14 + 8'(i), w[i]);
      end
      i_host_bfm.idle();
      chk({delta, step}, {w[1], w[2], w[0]});
      chk({en, period}, {w[4][5], w[4][7:6], w[3]});
      chk({pump, icur, dbl}, {w[5], w[6][7]});
      chk({third, fourth, level}, {w[7], w[9][1:0]});
      chk({hi, run, lock}, {w[8][7], w[8][5], w[8][3], w[8][1], w[8][4], w[8][2], w[8][0]});
      chk({flt, rdiv, src}, {w[4][4:0], w[6][6:0], w[8][6]});
      chk(oc, w[9][7:2]);
      for (int i = 0; i < 10; i++)
        rchk(8'h14 + 8'(i), w[i]);
    end
    i_host_bfm.wr_byte(8'h13, 8'hFF);
    i_host_bfm.wr_byte(8'h1E, 8'hFF);
    i_host_bfm.idle();
    rchk(8'h13, 8'h00);
    chk(hit, 1'b0);
    rchk(8'h14, w[0]);
    chk(hit, 1'b1);
    rchk(8'h1E, 8'h00);
    rchk(8'h1D, w[9]);
    i_host_bfm.wr_byte(8'h1C, 8'h3F);
    i_host_bfm.spread_setup(16'h1234, 8'h56, 10'h2C7, 5'h0E);
    i_host_bfm.idle();
    i_host_bfm.idle();
    chk({en, active, step_eff}, {2'h3, 20'h01234});
    chk({delta, period}, {8'h56, 10'h2C7});
    i_host_bfm.wr_byte(8'h1C, 8'hB7);
    i_host_bfm.idle();
    i_host_bfm.idle();
    chk({active, run, step_eff}, {1'b0, 3'h5, 20'h12340});
    for (int i = 0; i < 4; i++)
    begin
      i_host_bfm.wr_byte(8'h1A, dv[i]);
      i_host_bfm.idle();
      chk({dbl, div_eff}, {dv[i][7], de[i]});
    end
    i_host_bfm.wr_byte(8'h1D, 8'hB3);
    for (int p = 0; p < 2; p++)
    begin
      pin = p[0];
      i_host_bfm.idle();
      chk({a1, a2}, {p[0], 1'b1});
    end
    i_host_bfm.wr_byte(8'h1D, 8'h43);
    i_host_bfm.idle();
    i_host_bfm.idle();
    chk({a1, a2}, 2'h0);
    complete_run();
  end
endmodule
